// >>> tb_tpa_timer.sv
`timescale 1ns/1ns
`include "tpa_cfg.svh"
module tb_tpa_timer
  import tpa_pkg::*;
;
  // ****************************************
  // stimulus and bookkeeping
  // ****************************************
  logic        CLK_SYS_I = 1'b0;
  logic        NRST_I    = 1'b0;
  logic [7:0]  ADDR_I    = 8'h00;
  logic [7:0]  WDATA_I   = 8'h00;
  logic        WR_I      = 1'b0;
  logic        RD_I      = 1'b0;
  logic        PIN_DIR_I = 1'b0;
  logic [1:0]  VEC_ACK_I = 2'h0;
  logic [7:0]  RDATA_O;
  logic        WAVE_OUT_A_O;
  logic        WAVE_OE_O;
  logic        IRQ_O;
  int          n_fail    = 0;
  int          compares  = 0;
  logic [31:0] seed      = 32'h0000_0004;
  logic [7:0]  a_tab [7] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h40};
  logic [7:0]  r_tab [7] = '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};

  tpa_timer tpa_timer_i (.CLK_SYS_I(CLK_SYS_I), .NRST_I(NRST_I),
    .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
    .RDATA_O(RDATA_O), .PIN_DIR_I(PIN_DIR_I), .VEC_ACK_I(VEC_ACK_I),
    .WAVE_OUT_A_O(WAVE_OUT_A_O), .WAVE_OE_O(WAVE_OE_O), .IRQ_O(IRQ_O));

  // free-running system clock
  always #20 CLK_SYS_I = ~CLK_SYS_I;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // high clocks per period: held levels first, then match
  function automatic int exp_high(input int m, d, t, div);
    int h;
    h = (d == 0) ? 0 : (d == t) ? t + 1 : d - 1;
    if (m == 3)
      h = t + 1 - h;
    return h * div;
  endfunction

  task automatic chk(input string name, input logic [7:0] e, g);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge CLK_SYS_I);
  endtask

  // one-cycle write, then a gap so strobes never merge
  task automatic wr(input logic [7:0] a, d);
    ADDR_I  <= a;
    WDATA_I <= d;
    WR_I    <= 1'b1;
    tick(1);
    WR_I <= 1'b0;
    tick(1);
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    ADDR_I <= a;
    RD_I   <= 1'b1;
    tick(1);
    RD_I <= 1'b0;
    @(negedge CLK_SYS_I);
    v = RDATA_O;
    tick(1);
  endtask

  task automatic chk_irq(input logic e);
    @(negedge CLK_SYS_I);
    chk("interrupt", 8'(e), 8'(IRQ_O));
    tick(1);
  endtask

  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // hang guard
  initial
  begin
    tick(60000);
    n_fail++;
    finish_test();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    logic [7:0] v, w;
    int         t, d, p, hi;
    tick(2);
    NRST_I <= 1'b1;
    tick(1);
    wr(8'h40, 8'hFF);
    for (int i = 0; i < 7; i++)
    begin
      rd(a_tab[i], v);
      chk("reset value", r_tab[i], v);
    end
    repeat (4)
    begin
      v = 8'(rnd());
      wr(`TPA_OFF_CTRL, v);
      rd(`TPA_OFF_CTRL, w);
      chk("control", v, w);
    end
    // pwm sweep over fast select codes 1 to 4, pwm codes 01 to 11, corners
    // code 01 runs with the pin set to output, yet must stay undriven
    for (int s = 1; s <= 4; s++)
      for (int k = 1; k <= 3; k++)
      begin
        t = 3 + rnd() % 7;
        d = rnd() % (t + 1);
        d = (s == 2) ? t : (s == 3) ? 0 : (d == 1) ? 2 : d;
        p = (t + 1) << (s - 1);
        PIN_DIR_I <= (k != 2);
        wr(`TPA_OFF_CTRL, 8'h00);
        wr(`TPA_OFF_COUNT, 8'h00);
        wr(`TPA_OFF_TOP, 8'(t));
        wr(`TPA_OFF_DUTY, 8'(d));
        wr(`TPA_OFF_CTRL, 8'(8'h40 | (k << 4) | s));
        tick(3 * p);
        hi = 0;
        repeat (2 * p)
        begin
          @(negedge CLK_SYS_I);
          if (WAVE_OUT_A_O === 1'b1)
            hi++;
        end
        chk("output enable", 8'(k == 3), 8'(WAVE_OE_O));
        chk("high clocks", 8'(2 * exp_high(k, d, t, 1 << (s - 1))),
            8'(hi));
        tick(1);
      end
    // slow pwm: duty write waits in the buffer, reads back at once
    // an early load of 7 (the top) would force the output high
    wr(`TPA_OFF_CTRL, 8'h00);
    wr(`TPA_OFF_COUNT, 8'h00);
    wr(`TPA_OFF_TOP, 8'h07);
    wr(`TPA_OFF_DUTY, 8'h00);
    wr(`TPA_OFF_CTRL, 8'h6F);
    wr(`TPA_OFF_DUTY, 8'h07);
    rd(`TPA_OFF_DUTY, v);
    chk("duty readback", 8'h07, v);
    @(negedge CLK_SYS_I);
    chk("duty held back", 8'h00, 8'(WAVE_OUT_A_O));
    tick(1);
    wr(`TPA_OFF_CTRL, 8'h00);
    rd(`TPA_OFF_FLAGS, v);
    chk("wrap flag", 8'h01, 8'(v[0]));
    wr(`TPA_OFF_FLAGS, 8'h03);
    rd(`TPA_OFF_FLAGS, v);
    chk("flags cleared", 8'h00, v);
    // compare actions outside pwm: set, clear, toggle
    PIN_DIR_I <= 1'b1;
    wr(`TPA_OFF_DUTY, 8'h05);
    for (int k = 3; k >= 1; k--)
    begin
      wr(`TPA_OFF_COUNT, 8'h00);
      wr(`TPA_OFF_CTRL, 8'(8'h01 | (k << 4)));
      tick(8);
      wr(`TPA_OFF_CTRL, 8'(k << 4));
      @(negedge CLK_SYS_I);
      chk("compare output", 8'(k != 2), 8'(WAVE_OUT_A_O));
      tick(1);
    end
    wr(`TPA_OFF_MASK, 8'h02);
    chk_irq(1'b0);
    wr(`TPA_OFF_MASK, 8'h82);
    chk_irq(1'b1);
    VEC_ACK_I <= 2'b10;
    tick(1);
    VEC_ACK_I <= 2'b00;
    chk_irq(1'b0);
    // clear on match keeps count at or below threshold
    wr(`TPA_OFF_FLAGS, 8'h03);
    wr(`TPA_OFF_COUNT, 8'h00);
    wr(`TPA_OFF_CTRL, 8'h81);
    repeat (5)
    begin
      tick(rnd() % 5);
      rd(`TPA_OFF_COUNT, v);
      chk("count bounded", 8'h01, 8'(v <= 8'h05));
    end
    wr(`TPA_OFF_CTRL, 8'h00);
    rd(`TPA_OFF_FLAGS, v);
    chk("match flag only", 8'h02, v);
    rd(`TPA_OFF_COUNT, v);
    tick(5);
    rd(`TPA_OFF_COUNT, w);
    chk("stopped count", v, w);
    finish_test();
  end
endmodule

bind tpa_timer tpa_timer_properties tpa_timer_properties_i (
  .CLK_SYS_I(CLK_SYS_I), .NRST_I(NRST_I), .ADDR_I(ADDR_I),
  .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .PIN_DIR_I(PIN_DIR_I), .VEC_ACK_I(VEC_ACK_I),
  .WAVE_OUT_A_O(WAVE_OUT_A_O), .WAVE_OE_O(WAVE_OE_O), .IRQ_O(IRQ_O));

// >>> tpa_cfg.svh
`ifndef TPA_CFG_SVH
`define TPA_CFG_SVH

// ****************************************
// register offsets
// ****************************************
`define TPA_OFF_CTRL    8'h30
`define TPA_OFF_DUTY    8'h31
`define TPA_OFF_TOP     8'h32
`define TPA_OFF_COUNT   8'h33
`define TPA_OFF_FLAGS   8'h34
`define TPA_OFF_MASK    8'h35

// ****************************************
// field positions
// ****************************************
`define TPA_BIT_WRAP    0
`define TPA_BIT_MATCH   1
`define TPA_BIT_GLOBAL  7

// ****************************************
// reset values
// ****************************************
`define TPA_RST_CTRL    8'h00
`define TPA_RST_DUTY    8'h00
`define TPA_RST_TOP     8'hFF
`define TPA_RST_COUNT   8'h00
`define TPA_RST_FLAGS   2'h0
`define TPA_RST_MASK    3'h0

// ****************************************
// counter constants
// ****************************************
`define TPA_CNT_ONE     8'h01
`define TPA_CNT_ZERO    8'h00
`define TPA_CNT_FULL    8'hFF
`define TPA_SEL_STOP    4'h0
`define TPA_SEL_FAST_LAST 4'h4
`define TPA_SEL_SYS_BASE  4'h5
`define TPA_PRE_WIDTH   10

`endif

// >>> tpa_pkg.sv
package tpa_pkg;

  // ****************************************
  // output action codes
  // ****************************************
  typedef enum logic [1:0] {
    TPA_OUT_OFF    = 2'h0,
    TPA_OUT_TOGGLE = 2'h1,
    TPA_OUT_CLEAR  = 2'h2,
    TPA_OUT_SET    = 2'h3
  } tpa_out_mode_type;

  // control register layout
  typedef struct packed {
    logic             clear_on_match;
    logic             pwm_a_enable;
    tpa_out_mode_type out_mode;
    logic [3:0]       clk_sel;
  } tpa_ctrl_type;

  // sticky event flags
  typedef struct packed {
    logic match_a_flag;
    logic wrap_flag;
  } tpa_flags_type;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tpa_req_type;

endpackage

// >>> tpa_prescale.sv
`timescale 1ns/1ns
`include "tpa_cfg.svh"

module tpa_prescale
  import tpa_pkg::*;
#(
  parameter int PRE_WIDTH = `TPA_PRE_WIDTH
)(
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic [3:0] clk_sel_i,
  output logic            tick_o
);

  // ****************************************
  // divide exponent from select code
  // ****************************************
  function automatic logic [3:0] sel_exp(input logic [3:0] sel);
    logic [3:0] e;
    e = 4'h0;
    // fast clock codes map to divide by 1..8
    if (sel <= `TPA_SEL_FAST_LAST)
      e = sel - 4'h1;
    // system clock codes map to divide by 1..1024
    else
      e = sel - `TPA_SEL_SYS_BASE;
    return e;
  endfunction

  logic [PRE_WIDTH-1:0] pre_cnt;   // free-running divider
  logic [PRE_WIDTH-1:0] low_mask;  // bits that must all be ones

  // divider runs all the time
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      pre_cnt <= '0;
    else
      pre_cnt <= pre_cnt + 1'b1;
  end

  // mask of the low bits for the chosen ratio
  always_comb
  begin
    low_mask = PRE_WIDTH'((1 << sel_exp(clk_sel_i)) - 1);
  end

  always_comb
  begin
    tick_o = (clk_sel_i != `TPA_SEL_STOP) &&
             ((pre_cnt & low_mask) == low_mask);
  end

endmodule

// >>> tpa_timer.sv
// How it works
// - PWM counter counts zero to top, wraps
// - top match sets wrap flag one cycle later
// - PWM output codes: clear/set at match, count one
// - PWM threshold write buffered until top
// - threshold read returns latest written value
// - threshold zero or top holds constant level
// - flags raise interrupt when enabled and global
// - period equals top plus one ticks
// - control register at 0x30, fields, reset zero
// - clear-on-match resets counter after threshold match, with PWM off
// - PWM enable resets counter after top match
// - non-PWM match: off, toggle, clear, set
// - four-bit select picks counter clock
// - flags cleared by vector or write one
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
`include "tpa_cfg.svh"

module tpa_timer
  import tpa_pkg::*;
(
  input  wire logic       CLK_SYS_I,
  input  wire logic       NRST_I,
  input  wire logic [7:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  input  wire logic       PIN_DIR_I,
  input  wire logic [1:0] VEC_ACK_I,
  output logic            WAVE_OUT_A_O,
  output logic            WAVE_OE_O,
  output logic            IRQ_O
);

  // ****************************************
  // register port and state
  // ****************************************
  tpa_req_type      req;            // bundled register request
  tpa_ctrl_type     ctrl;           // timer_one_control
  logic [7:0]       duty_buf;       // most recently written threshold
  logic [7:0]       duty_act;       // threshold the compare uses
  logic [7:0]       period_top;     // period_top_reg
  logic [7:0]       count_value;    // running counter
  tpa_flags_type    flags;          // sticky event flags
  logic [2:0]       mask;           // enables, bit 2 is global
  logic             wave_out_a;     // output level
  logic             tick;           // timer clock tick
  logic             pwm;            // pwm mode active
  logic [7:0]       next_count;     // counter after this tick
  logic             at_top;         // counter at pwm top
  logic             match_a;        // threshold reached by counting
  logic             wrap_evt;       // wrap event this cycle
  logic             match_q;        // match delayed one cycle
  logic             wrap_q;         // wrap delayed one cycle
  logic [1:0]       clr_q;          // write-one clear, delayed
  logic             wr_count;       // software writes the counter

  // bundle the request lines
  always_comb
  begin
    req.addr  = ADDR_I;
    req.wdata = WDATA_I;
    req.wr    = WR_I;
    req.rd    = RD_I;
  end

  // ****************************************
  // timer clock
  // ****************************************
  tpa_prescale #(
    .PRE_WIDTH (`TPA_PRE_WIDTH)
  ) u_prescale (
    .clk_i     (CLK_SYS_I),
    .nrst_i    (NRST_I),
    .clk_sel_i (ctrl.clk_sel),
    .tick_o    (tick)
  );

  assign pwm      = ctrl.pwm_a_enable;
  assign at_top   = (count_value == period_top);
  assign wr_count = req.wr && (req.addr == `TPA_OFF_COUNT);

  // ****************************************
  // next count and events
  // ****************************************
  always_comb
  begin
    next_count = count_value + `TPA_CNT_ONE;
    // wrap to zero at top in pwm
    if (pwm && at_top)
      next_count = `TPA_CNT_ZERO;
    else if (!pwm && ctrl.clear_on_match &&
             (count_value == duty_act))
      next_count = `TPA_CNT_ZERO;
  end

  // threshold reached only by counting, never by a write
  assign match_a = tick && !wr_count && (next_count == duty_act);

  // top match is the wrap event in pwm
  always_comb
  begin
    if (pwm)
      wrap_evt = tick && !wr_count && at_top;
    else
      wrap_evt = tick && !wr_count &&
                 (count_value == `TPA_CNT_FULL);
  end

  // ****************************************
  // control register
  // ****************************************
  // control at its offset, reset zero
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
      ctrl <= tpa_ctrl_type'(`TPA_RST_CTRL);
    else if (req.wr && (req.addr == `TPA_OFF_CTRL))
      ctrl <= tpa_ctrl_type'(req.wdata);
  end

  // top register, plain storage
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
      period_top <= `TPA_RST_TOP;
    else if (req.wr && (req.addr == `TPA_OFF_TOP))
      period_top <= req.wdata;
  end

  // ****************************************
  // threshold double buffer
  // ****************************************
  // buffer holds the latest write
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
      duty_buf <= `TPA_RST_DUTY;
    else if (req.wr && (req.addr == `TPA_OFF_DUTY))
      duty_buf <= req.wdata;
  end

  // active threshold load
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
      duty_act <= `TPA_RST_DUTY;
    else if (pwm)
    begin
      if (tick && at_top)
        duty_act <= duty_buf;
    end
    // outside pwm the write takes effect at once
    else if (req.wr && (req.addr == `TPA_OFF_DUTY))
      duty_act <= req.wdata;
  end

  // ****************************************
  // counter
  // ****************************************
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
      count_value <= `TPA_RST_COUNT;
    // software write wins
    else if (wr_count)
      count_value <= req.wdata;
    // top plus one ticks per period
    else if (tick)
      count_value <= next_count;
  end

  // ****************************************
  // output waveform
  // ****************************************
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
      wave_out_a <= 1'b0;
    else if (pwm)
    begin
      if (duty_act == `TPA_CNT_ZERO)
        wave_out_a <= (ctrl.out_mode == TPA_OUT_SET);
      else if (duty_act == period_top)
        wave_out_a <= (ctrl.out_mode != TPA_OUT_SET);
      else if (match_a)
        wave_out_a <= (ctrl.out_mode == TPA_OUT_SET);
      else if (tick && (next_count == `TPA_CNT_ONE))
        wave_out_a <= (ctrl.out_mode != TPA_OUT_SET);
    end
    else if (match_a)
    begin
      unique case (ctrl.out_mode)
        TPA_OUT_OFF:    wave_out_a <= wave_out_a;
        TPA_OUT_TOGGLE: wave_out_a <= !wave_out_a;
        TPA_OUT_CLEAR:  wave_out_a <= 1'b0;
        TPA_OUT_SET:    wave_out_a <= 1'b1;
      endcase
    end
  end

  // drive only with pin set to output
  // pwm codes 00 and 01 leave pin free
  always_comb
  begin
    if (pwm)
      WAVE_OE_O = PIN_DIR_I && ctrl.out_mode[1];
    else
      WAVE_OE_O = PIN_DIR_I && (ctrl.out_mode != TPA_OUT_OFF);
  end

  assign WAVE_OUT_A_O = wave_out_a;

  // ****************************************
  // flags and interrupt
  // ****************************************
  // event and clear delays of one cycle
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      match_q <= 1'b0;
      wrap_q  <= 1'b0;
      clr_q   <= 2'h0;
    end
    else
    begin
      match_q <= match_a;
      wrap_q  <= wrap_evt;
      if (req.wr && (req.addr == `TPA_OFF_FLAGS))
        clr_q <= req.wdata[1:0];
      else
        clr_q <= 2'h0;
    end
  end

  // vector or write-one clears, set wins
  // wrap flag set one cycle after event
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
      flags <= tpa_flags_type'(`TPA_RST_FLAGS);
    else
    begin
      if (wrap_q)
        flags.wrap_flag <= 1'b1;
      else if (clr_q[`TPA_BIT_WRAP] || VEC_ACK_I[`TPA_BIT_WRAP])
        flags.wrap_flag <= 1'b0;
      if (match_q)
        flags.match_a_flag <= 1'b1;
      else if (clr_q[`TPA_BIT_MATCH] || VEC_ACK_I[`TPA_BIT_MATCH])
        flags.match_a_flag <= 1'b0;
    end
  end

  // mask register: wrap, match, global enable
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
      mask <= `TPA_RST_MASK;
    else if (req.wr && (req.addr == `TPA_OFF_MASK))
      mask <= {req.wdata[`TPA_BIT_GLOBAL], req.wdata[1:0]};
  end

  // flag and own enable and global enable
  assign IRQ_O = mask[2] && |(flags & mask[1:0]);

  // ****************************************
  // read data, valid one cycle after strobe
  // ****************************************
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
      RDATA_O <= 8'h00;
    else if (!req.rd)
      RDATA_O <= 8'h00;
    else
    begin
      unique case (req.addr)
        `TPA_OFF_CTRL:  RDATA_O <= ctrl;
        `TPA_OFF_DUTY:  RDATA_O <= duty_buf;
        `TPA_OFF_TOP:   RDATA_O <= period_top;
        `TPA_OFF_COUNT: RDATA_O <= count_value;
        `TPA_OFF_FLAGS: RDATA_O <= {6'h00, flags};
        `TPA_OFF_MASK:  RDATA_O <= {mask[2], 5'h00, mask[1:0]};
        default:        RDATA_O <= 8'h00;
      endcase
    end
  end

endmodule

// >>> tpa_timer_properties.sv
`timescale 1ns/1ns
`include "tpa_cfg.svh"
module tpa_timer_properties
  import tpa_pkg::*;
(
  input wire logic       CLK_SYS_I,
  input wire logic       NRST_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic       WR_I,
  input wire logic       RD_I,
  input wire logic [7:0] RDATA_O,
  input wire logic       PIN_DIR_I,
  input wire logic [1:0] VEC_ACK_I,
  input wire logic       WAVE_OUT_A_O,
  input wire logic       WAVE_OE_O,
  input wire logic       IRQ_O
);
  // ****************************************
  // shadow copies of written registers
  // ****************************************
  tpa_ctrl_type ctrl_sh; // control as last written
  logic [7:0]   mask_sh; // mask as last written

  // control shadow follows bus writes
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
      ctrl_sh <= tpa_ctrl_type'(`TPA_RST_CTRL);
    else if (WR_I && ADDR_I == `TPA_OFF_CTRL)
      ctrl_sh <= tpa_ctrl_type'(WDATA_I);
  end

  // mask shadow follows bus writes
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
      mask_sh <= 8'h00;
    else if (WR_I && ADDR_I == `TPA_OFF_MASK)
      mask_sh <= WDATA_I;
  end

  // ****************************************
  // port properties
  // ****************************************
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!NRST_I);

  rdata_idle_a: assert property (!RD_I |=> RDATA_O == 8'h00)
    else $error("read data not zero outside read");
  ctrl_readback_a: assert property (RD_I && ADDR_I == `TPA_OFF_CTRL
    |=> RDATA_O == $past(ctrl_sh)) else $error("control read mismatch");
  unmapped_read_a: assert property (RD_I && ADDR_I > `TPA_OFF_MASK
    |=> RDATA_O == 8'h00) else $error("unmapped read not zero");
  irq_gated_a: assert property (IRQ_O |-> mask_sh[7]
    && mask_sh[1:0] != 2'h0) else $error("interrupt without enables");
  oe_dir_a: assert property (WAVE_OE_O |-> PIN_DIR_I)
    else $error("pin driven while direction is input");
  oe_off_a: assert property (ctrl_sh.out_mode == TPA_OUT_OFF
    |-> !WAVE_OE_O) else $error("pin driven in off mode");
  pwm_toggle_off_a: assert property (ctrl_sh.pwm_a_enable
    && ctrl_sh.out_mode == TPA_OUT_TOGGLE |-> !WAVE_OE_O)
    else $error("pin driven in pwm code 01");
  stop_hold_a: assert property ((ctrl_sh.clk_sel == 4'h0
    && !ctrl_sh.pwm_a_enable) [*2] |=> $stable(WAVE_OUT_A_O))
    else $error("output moved while stopped");
endmodule
